// File: hdl/epc_defs.svh
// offsets, field positions, reset values and sizes of the nvm program controller
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH
// word addresses on the avalon bus (byte address = 4 * word)
`define EPC_ADDR_CTRL 16'hFE1D
`define EPC_ADDR_NVCFG 16'hFE1C
`define EPC_ADDR_SHADOW 16'hFE1F
`define EPC_ADDR_ARRAY_BASE 16'h0800
`define EPC_ADDR_ARRAY_LAST 16'h09FF
// control register fields
`define EPC_BIT_PUMP_CLK 7
`define EPC_BIT_PWR_DOWN 5
`define EPC_BIT_ERASE_HI 4
`define EPC_BIT_ERASE_LO 3
`define EPC_BIT_LATCH 2
`define EPC_BIT_HV 0
`define EPC_CTRL_RESET 8'h00
// configuration byte fields
`define EPC_BIT_REDUNDANT 7
`define EPC_CFG_MASK 8'h8F
`define EPC_ERASED_BYTE 8'hFF
// array geometry
`define EPC_ARRAY_BYTES 512
`define EPC_BLOCK_BYTES 128
`define EPC_HALF_BYTES 256
`endif

// File: hdl/epc_pkg.sv
// types shared by the nvm program controller
package epc_pkg;
   // erase mode selection
   typedef enum logic [1:0] {
      EPC_BYTE_PROGRAM,
      EPC_BYTE_ERASE,
      EPC_BLOCK_ERASE,
      EPC_BULK_ERASE
   } epc_mode_e;
   // sequencer states
   typedef enum logic [2:0] {
      EPC_IDLE,
      EPC_RD_MAIN,
      EPC_RD_MIRROR,
      EPC_HV_STEP,
      EPC_DONE
   } epc_state_e;
   // control register contents
   typedef struct packed {
      logic pump_clock_select;
      logic array_power_down;
      logic erase_mode_hi;
      logic erase_mode_lo;
      logic latch_enable;
      logic hv_enable;
   } epc_ctrl_s;
   // one memory port request
   typedef struct packed {
      logic we;
      logic [8:0] addr;
      logic [7:0] wdata;
   } epc_mem_req_s;
endpackage

// File: hdl/epc_array_mem.sv
// eeprom cell array model: 512 bytes, no config byte, registered read
`timescale 1ns/10ps
module epc_array_mem #(
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   input wire logic clock,
   input wire epc_pkg::epc_mem_req_s req,
   output logic [7:0] rdata
);
   // cell storage, content survives reset as non-volatile cells do
   logic [7:0] cells [0:DEPTH-1];

   // write port and registered read
   always_ff @(posedge clock) begin
      if (req.we) begin
         cells[req.addr] <= req.wdata;
      end
      rdata <= cells[req.addr];
   end
endmodule

// File: hdl/epc_ctrl.sv
// nvm program/erase controller with avalon-mm register and array access
`timescale 1ns/10ps
`include "epc_defs.svh"
module epc_ctrl (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   input wire logic stop_mode,
   input wire logic bus_clock_en,
   input wire logic rc_clock_en,
   output logic pump_enable,
   output logic pump_clock_en,
   output logic hv_applied,
   output logic array_enable
);
   logic rst_meta, rst_sync_n; // reset release pair
   logic stop_meta, stop_sync; // stop level synchroniser
   epc_pkg::epc_ctrl_s ctrl_reg; // control register
   logic [7:0] shadow_reg; // volatile config shadow
   logic latch_valid_reg; // a valid eeprom write is captured
   logic foreign_write_reg; // non-eeprom write seen while unlatched
   logic [8:0] latch_addr_reg; // captured byte address
   logic [7:0] latch_data_reg; // captured data
   epc_pkg::epc_state_e state_reg; // access sequencer
   logic [8:0] walk_reg; // erase walk index
   logic [7:0] main_reg; // first copy read
   logic [1:0] phase_reg; // per location: read, write, mirror write
   logic load_shadow_reg; // shadow load pending
   logic boot_reg; // reset-time shadow load pending
   epc_pkg::epc_mem_req_s mem_req; // array port
   logic [7:0] mem_rdata; // array read data
   logic wr_hv_done_reg; // hv step finished for this write
   logic [1:0] mode; // active erase mode
   logic is_array, is_ctrl, is_nv, is_shadow, is_upper; // decode
   logic [8:0] bus_idx; // array index of request
   logic redundant; // redundant mode active
   logic [3:0] prot_eff; // effective protection

   // reset release through two flops
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // stop request comes from another domain
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         stop_meta <= 1'b0;
         stop_sync <= 1'b0;
      end else begin
         stop_meta <= stop_mode;
         stop_sync <= stop_meta;
      end
   end

   // block number of an array index
   function automatic logic [1:0] blk_of(input logic [8:0] idx);
      blk_of = idx[8:7];
   endfunction

   // configuration view
   assign redundant = shadow_reg[`EPC_BIT_REDUNDANT];
   assign prot_eff = redundant ? {2'b00, shadow_reg[1:0]} : shadow_reg[3:0];
   assign mode = {ctrl_reg.erase_mode_hi, ctrl_reg.erase_mode_lo};

   // address decode
   always_comb begin
      is_array = 1'b0;
      is_ctrl = 1'b0;
      is_nv = 1'b0;
      is_shadow = 1'b0;
      if (avs_address >= `EPC_ADDR_ARRAY_BASE && avs_address <= `EPC_ADDR_ARRAY_LAST) begin
         is_array = 1'b1;
      end else if (avs_address == `EPC_ADDR_CTRL) begin
         is_ctrl = 1'b1;
      end else if (avs_address == `EPC_ADDR_NVCFG) begin
         is_nv = 1'b1;
      end else if (avs_address == `EPC_ADDR_SHADOW) begin
         is_shadow = 1'b1;
      end
   end
   assign bus_idx = avs_address[8:0];
   assign is_upper = is_array && redundant && bus_idx[8];

   // control register with its guarded writes
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ctrl_reg <= epc_pkg::epc_ctrl_s'(`EPC_CTRL_RESET);
      end else if (avs_write && is_ctrl && avs_byteenable[0] && !avs_waitrequest) begin
         if (!ctrl_reg.latch_enable || latch_valid_reg) begin
            ctrl_reg.pump_clock_select <= avs_writedata[`EPC_BIT_PUMP_CLK];
            ctrl_reg.array_power_down <= avs_writedata[`EPC_BIT_PWR_DOWN];
            if (!ctrl_reg.hv_enable) begin
               ctrl_reg.erase_mode_hi <= avs_writedata[`EPC_BIT_ERASE_HI];
               ctrl_reg.erase_mode_lo <= avs_writedata[`EPC_BIT_ERASE_LO];
            end
            // latch cannot drop while hv is set, even in the write that clears hv
            if (avs_writedata[`EPC_BIT_LATCH] || !ctrl_reg.hv_enable) begin
               ctrl_reg.latch_enable <= avs_writedata[`EPC_BIT_LATCH];
            end
            if (!avs_writedata[`EPC_BIT_HV]) begin
               ctrl_reg.hv_enable <= 1'b0;
            end else if (ctrl_reg.latch_enable && latch_valid_reg) begin
               ctrl_reg.hv_enable <= 1'b1;
            end else if (!foreign_write_reg && avs_writedata[`EPC_BIT_LATCH]) begin
               ctrl_reg.hv_enable <= 1'b0;
            end
         end
      end
   end

   // sticky record of non-eeprom writes while unlatched
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         foreign_write_reg <= 1'b0;
      end else if (avs_write && !avs_waitrequest && !is_array && !is_ctrl) begin
         foreign_write_reg <= !ctrl_reg.latch_enable;
      end else if (latch_valid_reg) begin
         foreign_write_reg <= 1'b0;
      end
   end

   // address and data capture
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         latch_valid_reg <= 1'b0;
         latch_addr_reg <= 9'h000;
         latch_data_reg <= 8'h00;
      end else if (!ctrl_reg.latch_enable) begin
         latch_valid_reg <= 1'b0;
      end else if (avs_write && !avs_waitrequest && (is_array || is_nv) && !is_upper
                   && !ctrl_reg.hv_enable) begin
         latch_valid_reg <= 1'b1;
         latch_addr_reg <= is_nv ? 9'h000 : bus_idx;
         latch_data_reg <= avs_writedata[7:0];
      end
   end
   logic latch_nv_reg; // captured target is the config byte
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         latch_nv_reg <= 1'b0;
      end else if (ctrl_reg.latch_enable && avs_write && !avs_waitrequest && (is_array || is_nv)
                   && !is_upper && !ctrl_reg.hv_enable) begin
         latch_nv_reg <= is_nv;
      end
   end

   // permission for voltage on the captured target
   logic target_ok; // captured target may be altered
   logic [7:0] nv_cell_reg; // config byte cell (separate from array)
   always_comb begin
      if (latch_nv_reg) begin
         target_ok = 1'b1;
      end else if (mode == epc_pkg::EPC_BULK_ERASE) begin
         target_ok = (prot_eff == 4'h0);
      end else begin
         target_ok = !prot_eff[blk_of(latch_addr_reg)];
      end
   end

   // pump and voltage outputs
   assign pump_enable = ctrl_reg.hv_enable && target_ok && !stop_sync;
   assign hv_applied = pump_enable && latch_valid_reg && !ctrl_reg.array_power_down;
   assign pump_clock_en = pump_enable &&
      (ctrl_reg.pump_clock_select ? bus_clock_en : rc_clock_en);
   assign array_enable = !ctrl_reg.array_power_down;

   // sequencer: reads, redundant reads and the hv cell update
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_reg <= epc_pkg::EPC_IDLE;
         walk_reg <= 9'h000;
         main_reg <= 8'h00;
         wr_hv_done_reg <= 1'b0;
         phase_reg <= 2'h0;
      end else begin
         case (state_reg)
            epc_pkg::EPC_IDLE: begin
               walk_reg <= latch_addr_reg;
               phase_reg <= 2'h0;
               if (avs_read && is_array && !is_upper && !(ctrl_reg.latch_enable
                   && latch_valid_reg)) begin
                  state_reg <= epc_pkg::EPC_RD_MAIN;
               end else if (hv_applied && !wr_hv_done_reg && !latch_nv_reg) begin
                  state_reg <= epc_pkg::EPC_HV_STEP;
                  if (mode == epc_pkg::EPC_BLOCK_ERASE) begin
                     walk_reg <= {latch_addr_reg[8:7], 7'h00};
                  end else if (mode == epc_pkg::EPC_BULK_ERASE) begin
                     walk_reg <= 9'h000;
                  end
               end
               if (!ctrl_reg.hv_enable) begin
                  wr_hv_done_reg <= 1'b0;
               end
            end
            epc_pkg::EPC_RD_MAIN: begin
               state_reg <= redundant ? epc_pkg::EPC_RD_MIRROR : epc_pkg::EPC_DONE;
            end
            epc_pkg::EPC_RD_MIRROR: begin
               main_reg <= mem_rdata;
               state_reg <= epc_pkg::EPC_DONE;
            end
            epc_pkg::EPC_HV_STEP: begin
               // a location is read, rewritten, then mirrored in redundant mode
               phase_reg <= 2'(phase_reg + 2'h1);
               if (!hv_applied) begin
                  wr_hv_done_reg <= 1'b1;
                  state_reg <= epc_pkg::EPC_IDLE;
               end else if (phase_reg == 2'h2 || (phase_reg == 2'h1 && !redundant)) begin
                  phase_reg <= 2'h0;
                  walk_reg <= 9'(walk_reg + 9'h001);
                  if (mode == epc_pkg::EPC_BYTE_PROGRAM || mode == epc_pkg::EPC_BYTE_ERASE
                      || (mode == epc_pkg::EPC_BLOCK_ERASE && walk_reg[6:0] == 7'h7F)
                      || walk_reg == 9'h1FF) begin
                     wr_hv_done_reg <= 1'b1;
                     state_reg <= epc_pkg::EPC_IDLE;
                  end
               end
            end
            default: begin
               state_reg <= epc_pkg::EPC_IDLE;
            end
         endcase
      end
   end

   // array port: byte program ands data in, erases write ones
   always_comb begin
      mem_req.we = 1'b0;
      mem_req.addr = bus_idx;
      mem_req.wdata = `EPC_ERASED_BYTE;
      if (state_reg == epc_pkg::EPC_RD_MIRROR) begin
         mem_req.addr = {1'b1, bus_idx[7:0]};
      end else if (state_reg == epc_pkg::EPC_HV_STEP) begin
         // phase 2 rewrites the upper copy with the value meant for the lower
         mem_req.addr = (phase_reg == 2'h2) ? {1'b1, walk_reg[7:0]} : walk_reg;
         mem_req.we = (phase_reg != 2'h0) && !prot_eff[blk_of(walk_reg)]
            && !(redundant && walk_reg[8]);
         if (mode == epc_pkg::EPC_BYTE_PROGRAM) begin
            mem_req.wdata = mem_rdata & latch_data_reg;
         end else begin
            mem_req.wdata = `EPC_ERASED_BYTE;
         end
      end
   end

   // cell array; read data come back one cycle after the address
   epc_array_mem #(.DEPTH(`EPC_ARRAY_BYTES), .AW(9)) u_mem (
      .clock(clock),
      .req(mem_req),
      .rdata(mem_rdata)
   );

   // config byte cell and its program/erase
   always_ff @(posedge clock) begin
      if (hv_applied && latch_nv_reg && !wr_hv_done_reg && state_reg == epc_pkg::EPC_IDLE) begin
         if (mode == epc_pkg::EPC_BYTE_PROGRAM) begin
            nv_cell_reg <= nv_cell_reg & latch_data_reg & `EPC_CFG_MASK;
         end else if (mode == epc_pkg::EPC_BYTE_ERASE) begin
            nv_cell_reg <= `EPC_ERASED_BYTE;
         end
      end
   end

   // shadow load at reset release and on nv reads
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         shadow_reg <= 8'h00;
         boot_reg <= 1'b1;
         load_shadow_reg <= 1'b0;
      end else begin
         boot_reg <= 1'b0;
         load_shadow_reg <= avs_read && is_nv && !avs_waitrequest;
         if (boot_reg || load_shadow_reg) begin
            shadow_reg <= nv_cell_reg & `EPC_CFG_MASK;
         end
      end
   end

   // avalon answer: reads of the array wait for the sequencer
   assign avs_waitrequest = (avs_read && is_array && !is_upper
      && !(ctrl_reg.latch_enable && latch_valid_reg) && state_reg != epc_pkg::EPC_DONE)
      || state_reg == epc_pkg::EPC_HV_STEP;
   always_comb begin
      avs_readdata = 32'h0000_0000;
      avs_response = 2'b00;
      if (is_ctrl) begin
         avs_readdata[7:0] = {ctrl_reg.pump_clock_select, 1'b0, ctrl_reg.array_power_down,
            ctrl_reg.erase_mode_hi, ctrl_reg.erase_mode_lo, ctrl_reg.latch_enable, 1'b0,
            ctrl_reg.hv_enable};
      end else if (is_nv) begin
         avs_readdata[7:0] = nv_cell_reg & `EPC_CFG_MASK;
      end else if (is_shadow) begin
         avs_readdata[7:0] = shadow_reg;
      end else if (is_array) begin
         if (is_upper) begin
            avs_readdata[7:0] = `EPC_ERASED_BYTE;
         end else if (ctrl_reg.latch_enable && latch_valid_reg) begin
            avs_readdata[7:0] = latch_data_reg;
         end else if (redundant) begin
            avs_readdata[7:0] = main_reg & mem_rdata;
         end else begin
            avs_readdata[7:0] = mem_rdata;
         end
      end else begin
         avs_response = 2'b11;
      end
   end
endmodule

// File: verif/epc_ctrl_props.sv
// port-level assertions for the nvm program controller
`timescale 1ns/10ps
`include "epc_defs.svh"
module epc_ctrl_props (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   input wire logic stop_mode,
   input wire logic bus_clock_en,
   input wire logic rc_clock_en,
   input wire logic pump_enable,
   input wire logic pump_clock_en,
   input wire logic hv_applied,
   input wire logic array_enable
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic req; // any request on the bus
   logic arr; // request aimed at the cell array
   logic ctl_rd; // accepted read of the control register
   logic sh_rd; // accepted read of the shadow register
   assign req = avs_read || avs_write;
   assign arr = avs_address >= `EPC_ADDR_ARRAY_BASE && avs_address <= `EPC_ADDR_ARRAY_LAST;
   assign ctl_rd = avs_read && !avs_waitrequest && avs_address == `EPC_ADDR_CTRL;
   assign sh_rd = avs_read && !avs_waitrequest && avs_address == `EPC_ADDR_SHADOW;
   // registers answer without wait states unless a cell update is running
   AST_REG_NO_WAIT: assert property (req && !$past(hv_applied) &&
      (avs_address == `EPC_ADDR_CTRL || avs_address == `EPC_ADDR_SHADOW) |-> !avs_waitrequest)
      else $error("register waited");
   // array reads answer within four wait states
   AST_ARRAY_READ_BOUND: assert property (avs_read && arr |-> ##[0:4] !avs_waitrequest)
      else $error("array read not answered");
   // holes in the map give an error response
   AST_UNMAPPED: assert property (req && !avs_waitrequest && avs_address > 16'h09FF &&
      avs_address < 16'hFE00 |-> avs_response == 2'b11) else $error("unmapped not flagged");
   AST_CTRL_OKAY: assert property (ctl_rd |-> avs_response == 2'b00)
      else $error("control read flagged");
   AST_CTRL_ZEROS: assert property (ctl_rd |-> !avs_readdata[6] && !avs_readdata[1])
      else $error("reserved control bits set");
   AST_PWR_READBACK: assert property (ctl_rd |-> avs_readdata[5] == !array_enable)
      else $error("power-down bit and array enable disagree");
   AST_HV_READBACK: assert property (ctl_rd && !avs_readdata[0] |-> !pump_enable)
      else $error("pump on with hv bit clear");
   AST_SHADOW_MASK: assert property (sh_rd |-> avs_readdata[6:4] == 3'h0)
      else $error("reserved shadow bits set");
   AST_STOP_DROPS_HV: assert property (stop_mode [*5] |-> !hv_applied && !pump_enable)
      else $error("voltage on in stop mode");
   AST_RESET_STATE: assert property ($rose(rst_n) |-> !pump_enable && array_enable)
      else $error("outputs not cleared by reset");
   // main scenarios reached
   COV_PUMP: cover property (pump_enable);
   COV_ARRAY_WAIT: cover property (avs_read && arr && avs_waitrequest);
   COV_STOP: cover property (stop_mode && hv_applied);
endmodule

// File: verif/epc_cpu_model.sv
// cpu-side avalon master model that issues the program/erase bus cycles
`timescale 1ns/10ps
module epc_cpu_model (
   input wire logic clock,
   output logic [15:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response
);
   // idle bus from time zero
   initial begin
      avs_address = 16'h0000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
   end
   // one byte-wide transfer; request held until waitrequest is low at an edge
   task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
         output logic [7:0] q, output logic [1:0] r);
      @(posedge clock);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= {24'h00_0000, d};
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clock);
      end
      q = avs_readdata[7:0];
      r = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= ~avs_writedata;  // stale data never looks valid
   endtask
endmodule

// File: verif/tb_eeprom_program_erase_ctrl.sv
// self-checking bench for the nvm program/erase controller
`timescale 1ns/10ps
`include "epc_defs.svh"
module tb_eeprom_program_erase_ctrl;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic stop_mode = 1'b0;
   logic bus_clock_en = 1'b0;
   logic rc_clock_en = 1'b0;
   logic [1:0] div = 2'h0; // rc pulse divider
   logic [15:0] adr;
   logic rd_s, wr_s, wait_s, pump, pclk, hv, arr_en;
   logic [31:0] wdat, rdat;
   logic [3:0] be;
   logic [1:0] resp;
   logic [7:0] q; // last read byte
   logic [1:0] r; // last response
   int n_fail = 0;
   int compares = 0;
   // 100 MHz clock
   always #5 clock = ~clock;
   // pump clock sources: bus every other cycle, rc every fourth
   always @(posedge clock) begin
      bus_clock_en <= ~bus_clock_en;
      div <= div + 2'h1;
      rc_clock_en <= (div == 2'h3);
   end
   epc_ctrl u_dut (.clock(clock), .rst_n(rst_n), .avs_address(adr), .avs_read(rd_s),
      .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wait_s), .avs_response(resp), .stop_mode(stop_mode),
      .bus_clock_en(bus_clock_en), .rc_clock_en(rc_clock_en), .pump_enable(pump),
      .pump_clock_en(pclk), .hv_applied(hv), .array_enable(arr_en));
   epc_cpu_model u_cpu (.clock(clock), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
      .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wait_s), .avs_response(resp));
   // compare and count
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      u_cpu.xfer(1'b1, a, d, q, r);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      u_cpu.xfer(1'b0, a, 8'h00, q, r);
      check(q, e);
   endtask
   // latch, load target, voltage on, wait, voltage off, wait, unlatch
   task automatic op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d,
         input logic p);
      wr(`EPC_ADDR_CTRL, {3'h0, m, 3'h4});
      wr(a, d);
      wr(`EPC_ADDR_CTRL, {3'h0, m, 3'h5});
      repeat (4) @(posedge clock);
      check({7'h00, pump}, {7'h00, p});
      wr(`EPC_ADDR_CTRL, {3'h0, m, 3'h4});
      repeat (4) @(posedge clock);
      wr(`EPC_ADDR_CTRL, 8'h00);
   endtask
   // erase then program the config byte, then reload the shadow
   task automatic cfg(input logic [7:0] v);
      op(2'h1, `EPC_ADDR_NVCFG, 8'h00, 1'b1);
      op(2'h0, `EPC_ADDR_NVCFG, v, 1'b1);
      rd(`EPC_ADDR_NVCFG, v);
      rd(`EPC_ADDR_SHADOW, v);
   endtask
   task automatic t_reset();
      rd(`EPC_ADDR_CTRL, 8'h00);
      u_cpu.xfer(1'b0, 16'h1234, 8'h00, q, r);
      check({6'h00, r}, 8'h03);
      wr(16'h1234, 8'h55);
      wr(`EPC_ADDR_CTRL, 8'h01);
      rd(`EPC_ADDR_CTRL, 8'h00);
      wr(`EPC_ADDR_CTRL, 8'hA0);
      rd(`EPC_ADDR_CTRL, 8'hA0);
      check({7'h00, arr_en}, 8'h00);
      wr(`EPC_ADDR_CTRL, 8'h00);
   endtask
   task automatic t_program();
      cfg(8'h01);
      op(2'h1, 16'h0880, 8'h00, 1'b1);
      rd(16'h0880, 8'hFF);
      op(2'h0, 16'h0880, 8'hA5, 1'b1);
      rd(16'h0880, 8'hA5);
      op(2'h0, 16'h0880, 8'h5A, 1'b1);
      rd(16'h0880, 8'h00);
      op(2'h1, 16'h0800, 8'h00, 1'b0);
      op(2'h3, 16'h0880, 8'h00, 1'b0);
      op(2'h2, 16'h0881, 8'h00, 1'b1);
      rd(16'h08FF, 8'hFF);
      rd(16'h0880, 8'hFF);
      rd(`EPC_ADDR_NVCFG, 8'h01);
   endtask
   task automatic t_latch();
      wr(`EPC_ADDR_CTRL, 8'h04);
      wr(`EPC_ADDR_CTRL, 8'h14);
      rd(`EPC_ADDR_CTRL, 8'h04);
      wr(16'h0900, 8'h11);
      wr(16'h0901, 8'h22);
      rd(16'h0880, 8'h22);
      wr(`EPC_ADDR_CTRL, 8'h05);
      wr(`EPC_ADDR_CTRL, 8'h1D);
      rd(`EPC_ADDR_CTRL, 8'h05);
      wr(`EPC_ADDR_CTRL, 8'h01);
      rd(`EPC_ADDR_CTRL, 8'h05);
      wr(`EPC_ADDR_CTRL, 8'h00);
      rd(`EPC_ADDR_CTRL, 8'h04);
      wr(`EPC_ADDR_CTRL, 8'h00);
      rd(`EPC_ADDR_CTRL, 8'h00);
   endtask
   task automatic t_redundant();
      cfg(8'h8C);
      op(2'h1, 16'h0810, 8'h00, 1'b1);
      op(2'h0, 16'h0810, 8'h3C, 1'b1);
      rd(16'h0810, 8'h3C);
      rd(16'h0910, 8'hFF);
      cfg(8'h00);
      rd(16'h0910, 8'h3C);
   endtask
   task automatic t_stop();
      wr(`EPC_ADDR_CTRL, 8'h04);
      wr(16'h0880, 8'hFF);
      wr(`EPC_ADDR_CTRL, 8'h05);
      repeat (4) begin
         @(posedge clock);
         check({7'h00, pclk}, {7'h00, rc_clock_en});
      end
      check({7'h00, hv}, 8'h01);
      wr(`EPC_ADDR_CTRL, 8'h85);
      repeat (2) begin
         @(posedge clock);
         check({7'h00, pclk}, {7'h00, bus_clock_en});
      end
      stop_mode <= 1'b1;
      repeat (6) @(posedge clock);
      check({7'h00, hv}, 8'h00);
      rd(`EPC_ADDR_CTRL, 8'h85);
      stop_mode <= 1'b0;
      repeat (6) @(posedge clock);
      check({7'h00, hv}, 8'h01);
      wr(`EPC_ADDR_CTRL, 8'h04);
      wr(`EPC_ADDR_CTRL, 8'h00);
   endtask
   // verdict and end of run
   task automatic results();
      if (n_fail == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      t_reset();
      t_program();
      t_latch();
      t_redundant();
      t_stop();
      results();
   end
   // watchdog against a hung handshake
   initial begin
      #300000;
      n_fail++;
      results();
   end
endmodule
bind epc_ctrl epc_ctrl_props u_props (.clock(clock), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .avs_response(avs_response), .stop_mode(stop_mode), .bus_clock_en(bus_clock_en),
   .rc_clock_en(rc_clock_en), .pump_enable(pump_enable), .pump_clock_en(pump_clock_en),
   .hv_applied(hv_applied), .array_enable(array_enable));
